/* logic/quad_reg_clock_enable_tristate.sv */
// four bit register with two gated load enables, async clear and
// gated three-state outputs, plus a small apb window for software
// assumes all pins but async_clear are synchronous to pclk; the bus wire itself is
// resolved outside from bus_out and bus_out_oe
`include "quad_reg_params.svh"

// Contract
// R01: four stored bits with parallel inputs and outputs all update together on one clock.
// R02: at a rising sample edge with both load gates low the four data inputs are captured.
// R03: at a rising sample edge with either load gate high the stored value is kept.
// R04: the clear input is active high and acts without waiting for any clock edge.
// R05: while clear is high all stored bits are zero whatever the other inputs do.
// R06: with both drive gates low the stored bits are driven onto the four outputs; the code also needs the software float bit clear.
// R07: with either drive gate high all four outputs float.
// R08: the drive gates never change loading, holding or clearing.
// R09: a drive gate change never disturbs a load or clear in the same moment.
// R10: between rising sample edges the stored value changes only through the clear.
module quad_reg_clock_enable_tristate (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire quad_reg_pkg::apb_addr_t paddr,
  input wire quad_reg_pkg::word_t pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_clock,
  input wire logic async_clear,
  input wire logic load_gate_a_n,
  input wire logic load_gate_b_n,
  input wire logic drive_gate_a_n,
  input wire logic drive_gate_b_n,
  input wire quad_reg_pkg::nibble_t parallel_in,
  output logic [3:0] bus_out,
  output logic bus_out_oe
);
  import quad_reg_pkg::*;

  // ----------------------------------------------------------------------
  // sample clock edge detect
  // ----------------------------------------------------------------------
  logic sample_prev_ff;
  logic nxt_sample_prev;
  logic sample_edge;

  // a rise shows as one pclk with the pin high and the flop still low;
  // the pin must stay low a full pclk between rises or a rise is lost
  // pin is synchronous to pclk, so no synchroniser is needed here
  always_comb begin
    nxt_sample_prev = sample_clock;
  end

  // previous pin level, one pclk old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_prev_ff <= 1'b1;
    end else begin
      sample_prev_ff <= nxt_sample_prev;
    end
  end

  // held high at reset so a pin already high is not a false edge
  assign sample_edge = sample_clock & ~sample_prev_ff;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  nibble_t store_ff;
  nibble_t nxt_store;
  logic load_now;

  // drive gates take no part in this term at all
  assign load_now = sample_edge & ~load_gate_a_n & ~load_gate_b_n; // see R02 R08 R09

  // load and hold share one mux; the flops themselves carry no enable
  // one shared edge for all four bits
  always_comb begin
    nxt_store = store_ff; // see R03 R10
    if (load_now) begin
      nxt_store = parallel_in; // see R01 R02
    end
  end

  // a clear pulse shorter than a pclk still empties the store, since
  // the flops see its rising edge directly
  // clear overrides everything, with or without pclk running
  always_ff @(posedge pclk or negedge presetn or posedge async_clear) begin
    if (!presetn) begin
      store_ff <= `QR_STORE_RST;
    end else if (async_clear) begin
      store_ff <= `QR_STORE_RST; // see R04 R05
    end else begin
      store_ff <= nxt_store;
    end
  end

  // ----------------------------------------------------------------------
  // three-state output control
  // ----------------------------------------------------------------------
  logic drive_ff;
  logic nxt_drive;
  logic float_ctl_ff;
  logic nxt_float_ctl;

  // trade-off: one pclk of lag buys an enable with no decode glitches
  // registered enable lags the gates by one pclk; software float adds to it
  always_comb begin
    nxt_drive = ~drive_gate_a_n & ~drive_gate_b_n & ~float_ctl_ff; // see R06 R07
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  // stored bits always visible here; the wire outside floats them on !oe
  assign bus_out = store_ff; // see R06
  assign bus_out_oe = drive_ff; // see R07

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  word_t rdata_ff;
  word_t nxt_rdata;
  logic ready_ff;
  logic nxt_ready;
  logic err_ff;
  logic nxt_err;
  logic edge_seen_ff;
  logic nxt_edge_seen;
  logic setup_ph;
  logic access_done;
  logic hit_status;
  logic hit_control;

  // decode on the full byte address; an unaligned offset is unmapped
  assign setup_ph = psel & ~penable;
  assign access_done = psel & penable & ready_ff;
  assign hit_status = (paddr == `QR_STATUS_OFS);
  assign hit_control = (paddr == `QR_CONTROL_OFS);

  // answer is prepared in setup so every bus output is a flop
  always_comb begin
    nxt_ready = setup_ph;
    nxt_err = setup_ph & ~hit_status & ~hit_control;
    nxt_rdata = 32'h0000_0000;
    nxt_float_ctl = float_ctl_ff;
    nxt_edge_seen = edge_seen_ff | sample_edge;
    // read data is taken in setup, so it shows the store as of setup
    if (setup_ph && !pwrite && hit_status) begin
      nxt_rdata[`QR_ST_VALUE_LSB +: 4] = store_ff;
      nxt_rdata[`QR_ST_DRIVE_BIT] = drive_ff;
      nxt_rdata[`QR_ST_EDGE_BIT] = edge_seen_ff;
    end
    if (setup_ph && !pwrite && hit_control) begin
      nxt_rdata[`QR_CTL_FLOAT_BIT] = float_ctl_ff;
    end
    // software float only changes on the committing access edge
    if (access_done && pwrite && hit_control) begin
      nxt_float_ctl = pwdata[`QR_CTL_FLOAT_BIT];
    end
    // a write to status clears the edge flag; a new edge wins
    if (access_done && pwrite && hit_status) begin
      nxt_edge_seen = sample_edge;
    end
  end

  // bus answer and software state, all idle out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      float_ctl_ff <= `QR_CONTROL_RST;
      edge_seen_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
      float_ctl_ff <= nxt_float_ctl;
      edge_seen_ff <= nxt_edge_seen;
    end
  end

  // every bus output comes straight from a flop
  assign prdata = rdata_ff;
  assign pready = ready_ff;
  assign pslverr = err_ff;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // load, hold and sample timing of the store
  a_load_both_low: assert property (@(posedge pclk) // see R02
    disable iff (!presetn || async_clear)
    sample_edge && !load_gate_a_n && !load_gate_b_n |=> store_ff == $past(parallel_in))
    else $error("load with both gates low missed");

  a_hold_gate_high: assert property (@(posedge pclk) // see R03
    disable iff (!presetn || async_clear)
    sample_edge && (load_gate_a_n || load_gate_b_n) |=> $stable(store_ff))
    else $error("store changed with a load gate high");

  a_hold_no_edge: assert property (@(posedge pclk) // see R10
    disable iff (!presetn || async_clear)
    !sample_edge |=> $stable(store_ff))
    else $error("store changed without a sample edge");

  a_outputs_all_four: assert property (@(posedge pclk) // see R01
    disable iff (!presetn || async_clear)
    load_now ##1 !async_clear |-> bus_out == $past(parallel_in))
    else $error("outputs did not follow all four bits");

  // clear wins over everything, with no edge needed
  a_clear_forces_zero: assert property (@(posedge pclk) // see R05
    disable iff (!presetn)
    async_clear |-> store_ff == 4'h0 && bus_out == 4'h0)
    else $error("store not zero while clear high");

  a_clear_no_edge: assert property (@(posedge pclk) // see R04
    disable iff (!presetn)
    $rose(async_clear) && !sample_edge |-> store_ff == 4'h0)
    else $error("clear waited for an edge");

  a_clear_blocks_load: assert property (@(posedge pclk) // see R05
    disable iff (!presetn)
    async_clear && load_now |=> store_ff == 4'h0)
    else $error("load got through a clear");

  // output enable follows the drive gates and the software float bit
  a_drive_enable: assert property (@(posedge pclk) // see R06
    disable iff (!presetn)
    !drive_gate_a_n && !drive_gate_b_n && !float_ctl_ff |=> bus_out_oe)
    else $error("outputs not driven with both gates low");

  a_float_gate: assert property (@(posedge pclk) // see R07
    disable iff (!presetn)
    drive_gate_a_n || drive_gate_b_n |=> !bus_out_oe)
    else $error("outputs driven with a drive gate high");

  a_float_bit_off: assert property (@(posedge pclk) // see R07
    disable iff (!presetn)
    float_ctl_ff |=> !bus_out_oe)
    else $error("outputs driven with software float set");

  a_float_write: assert property (@(posedge pclk) // see R07
    disable iff (!presetn)
    access_done && pwrite && hit_control |=>
      float_ctl_ff == $past(pwdata[`QR_CTL_FLOAT_BIT]))
    else $error("float bit write lost");

  // drive gates stay out of the store path
  a_load_while_float: assert property (@(posedge pclk) // see R08
    disable iff (!presetn || async_clear)
    load_now && (drive_gate_a_n || drive_gate_b_n) |=> store_ff == $past(parallel_in))
    else $error("floating outputs blocked a load");

  a_drive_b_hold: assert property (@(posedge pclk) // see R08
    disable iff (!presetn || async_clear)
    $changed(drive_gate_b_n) && !load_now |=> $stable(store_ff))
    else $error("drive gate change moved the store");

  a_gate_change_load: assert property (@(posedge pclk) // see R09
    disable iff (!presetn || async_clear)
    load_now && $changed(drive_gate_a_n) |=> store_ff == $past(parallel_in))
    else $error("drive gate change disturbed a load");

  a_drive_b_load: assert property (@(posedge pclk) // see R09
    disable iff (!presetn || async_clear)
    load_now && $changed(drive_gate_b_n) |=> store_ff == $past(parallel_in))
    else $error("second drive gate change disturbed a load");

  // edge flag and bus answer timing
  a_edge_flag_set: assert property (@(posedge pclk) // see R02
    disable iff (!presetn)
    sample_edge |=> edge_seen_ff)
    else $error("sample edge not flagged");

  a_edge_flag_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    access_done && pwrite && hit_status && !sample_edge |=> !edge_seen_ff)
    else $error("status write did not clear the edge flag");

  a_ready_after_setup: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup_ph |=> pready)
    else $error("no ready in the access cycle");

  a_ready_one_cycle: assert property (@(posedge pclk)
    disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stood past the access cycle");

  a_err_unmapped: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup_ph && !hit_status && !hit_control |=> pready && pslverr)
    else $error("unmapped access not refused");

  a_mapped_no_err: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup_ph && (hit_status || hit_control) |=> !pslverr)
    else $error("mapped access refused");

  // ----------------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------------
  // main scenarios: load, clear, float to drive, status read, gated hold
  c_load: cover property (@(posedge pclk) disable iff (!presetn) load_now);
  c_clear: cover property (@(posedge pclk) disable iff (!presetn) $rose(async_clear));
  c_float_to_drive: cover property (@(posedge pclk) disable iff (!presetn)
    !bus_out_oe ##1 bus_out_oe);
  c_apb_read: cover property (@(posedge pclk) disable iff (!presetn)
    access_done && !pwrite && hit_status);
  c_gate_hold: cover property (@(posedge pclk) disable iff (!presetn)
    sample_edge && (load_gate_a_n || load_gate_b_n));

endmodule

/* logic/quad_reg_params.svh */
// constants for the gated-load four bit register with floating outputs
// assumes inclusion by the register top only; the bench does not include it
`ifndef QUAD_REG_PARAMS_SVH
`define QUAD_REG_PARAMS_SVH

// ----------------------------------------------------------------------
// register map, byte addresses on the apb side
// ----------------------------------------------------------------------
`define QR_STATUS_OFS 12'h000
`define QR_CONTROL_OFS 12'h004

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define QR_ST_VALUE_LSB 0
`define QR_ST_DRIVE_BIT 4
`define QR_ST_EDGE_BIT 5
`define QR_CTL_FLOAT_BIT 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define QR_STORE_RST 4'h0
`define QR_CONTROL_RST 1'b0

`endif

/* logic/quad_reg_pkg.sv */
// types shared by the gated-load register top and its bench
// assumes nothing of its surroundings
package quad_reg_pkg;

  // ----------------------------------------------------------------------
  // data types
  // ----------------------------------------------------------------------
  typedef logic [3:0] nibble_t;
  typedef logic [31:0] word_t;
  typedef logic [11:0] apb_addr_t;

endpackage

/* tb/quad_bus_model.sv */
// far-side model of the shared data bus that the register drives
// assumes bus_out and bus_out_oe come straight from the register top
module quad_bus_model (
  input wire quad_reg_pkg::nibble_t bus_out,
  input wire logic bus_out_oe,
  output quad_reg_pkg::nibble_t bus_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  import quad_reg_pkg::*;
  nibble_t held_val = 4'h0;
  // ----------------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------------
  // no keeper on a released bus: show the inverse so a stale value never matches
  always @(bus_out or bus_out_oe) begin
    if (bus_out_oe) begin
      held_val = bus_out;
    end
  end
  assign bus_wire = bus_out_oe ? bus_out : ~held_val;
endmodule

/* tb/quad_reg_clock_enable_tristate_tb.sv */
// self-checking bench: apb and pin tasks, then sequences of calls
// assumes the package, the register top and the bus model are compiled first
module quad_reg_clock_enable_tristate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import quad_reg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, bus_out_oe;
  logic sample_clock = 0, async_clear = 0, load_gate_a_n = 1, load_gate_b_n = 1;
  logic drive_gate_a_n = 1, drive_gate_b_n = 1;
  apb_addr_t paddr = 12'h000;
  word_t pwdata = 32'h0, prdata, q;
  nibble_t parallel_in = 4'h0, bus_out, bus_wire;
  int n_errors = 0, checked = 0;
  logic err;
  always #5 pclk = ~pclk;
  quad_reg_clock_enable_tristate quad_reg_clock_enable_tristate_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_clock(sample_clock),
    .async_clear(async_clear), .load_gate_a_n(load_gate_a_n), .load_gate_b_n(load_gate_b_n),
    .drive_gate_a_n(drive_gate_a_n), .drive_gate_b_n(drive_gate_b_n),
    .parallel_in(parallel_in), .bus_out(bus_out), .bus_out_oe(bus_out_oe));
  quad_bus_model quad_bus_model_i (.bus_out(bus_out), .bus_out_oe(bus_out_oe), .bus_wire(bus_wire));
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input word_t exp, input word_t got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input apb_addr_t a, input word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one rise of the register clock pin, then low again so the next rise is seen
  task automatic load(input nibble_t d, input logic ga, input logic gb);
    @(posedge pclk);
    parallel_in <= d;
    load_gate_a_n <= ga;
    load_gate_b_n <= gb;
    @(posedge pclk);
    sample_clock <= 1'b1;
    @(posedge pclk);
    sample_clock <= 1'b0;
    #1;
  endtask
  task automatic drive(input logic a, input logic b);
    @(posedge pclk);
    drive_gate_a_n <= a;
    drive_gate_b_n <= b;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    end_of_test();
  end
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("status after reset", 32'h0, q);
    apb(1'b1, 12'h008, 32'hF);
    chk("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped read data", 32'h0, q);
    $display("test reset and map done");
    load(4'hA, 1'b0, 1'b0);
    chk("loaded value", 32'hA, {28'h0, bus_out});
    load(4'h5, 1'b0, 1'b0);
    drive(1'b0, 1'b0);
    chk("driven wire", 32'h5, {28'h0, bus_wire});
    chk("drive enable", 32'h1, {31'h0, bus_out_oe});
    apb(1'b0, 12'h000, 32'h0);
    chk("status value", 32'h15, {26'h0, q[5:0]} & 32'h1F);
    chk("edge flag set", 32'h1, {31'h0, q[5]});
    chk("mapped read error", 32'h0, {31'h0, err});
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("edge flag cleared", 32'h0, {31'h0, q[5]});
    for (int g = 1; g < 4; g++) begin
      load(4'h0, g[1], g[0]);
      chk("held value", 32'h5, {28'h0, bus_out});
    end
    $display("test load and hold done");
    for (int g = 1; g < 4; g++) begin
      drive(g[1], g[0]);
      chk("floating enable", 32'h0, {31'h0, bus_out_oe});
      chk("floating wire", 32'hA, {28'h0, bus_wire});
      load(nibble_t'(g), 1'b0, 1'b0);
      chk("load while floating", word_t'(g), {28'h0, bus_out});
    end
    drive(1'b0, 1'b0);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("float bit readback", 32'h1, q);
    repeat (2) @(posedge pclk);
    chk("software float", 32'h0, {31'h0, bus_out_oe});
    apb(1'b1, 12'h004, 32'h0);
    $display("test floating done");
    @(posedge pclk);
    async_clear <= 1'b1;
    drive_gate_a_n <= 1'b1;
    #2;
    chk("clear before next edge", 32'h0, {28'h0, bus_out});
    load(4'hF, 1'b0, 1'b0);
    chk("load under clear", 32'h0, {28'h0, bus_out});
    @(posedge pclk);
    async_clear <= 1'b0;
    load(4'h6, 1'b0, 1'b0);
    @(posedge pclk);
    parallel_in <= 4'h9;
    repeat (3) @(posedge pclk);
    chk("no edge no change", 32'h6, {28'h0, bus_out});
    // both drive gates flip on the very edge that loads
    @(posedge pclk);
    parallel_in <= 4'hC;
    @(posedge pclk);
    sample_clock <= 1'b1;
    drive_gate_a_n <= 1'b0;
    drive_gate_b_n <= 1'b1;
    @(posedge pclk);
    sample_clock <= 1'b0;
    #1;
    chk("load with gate change", 32'hC, {28'h0, bus_out});
    $display("test clear and sampling done");
    end_of_test();
  end
endmodule
